/* rtl/fan_cfg_defs.svh */
`ifndef FAN_CFG_DEFS_SVH
`define FAN_CFG_DEFS_SVH
// register offsets
`define ADDR_CTRL_LOCK 8'h40
`define ADDR_Z2_RANGE 8'h60
`define ADDR_Z3_RANGE 8'h61
`define ADDR_MIN_OFF 8'h62
`define ADDR_Z23_SMOOTH 8'h63
`define ADDR_F1_PWM_MIN 8'h64
`define ADDR_F2_PWM_MIN 8'h65
`define ADDR_F3_PWM_MIN 8'h66
`define ADDR_Z1_FAN_LIM 8'h67
`define ADDR_Z2_FAN_LIM 8'h68
`define ADDR_Z3_FAN_LIM 8'h69
`define ADDR_Z1_ABS_LIM 8'h6A
`define ADDR_Z2_ABS_LIM 8'h6B
`define ADDR_Z3_ABS_LIM 8'h6C
`define ADDR_Z12_HYST 8'h6D
`define ADDR_Z34_HYST 8'h6E
`define ADDR_PARITY_EN 8'h6F
`define ADDR_SPINUP 8'h75
// reset values
`define RST_RANGE 8'hC3
`define RST_ZERO 8'h00
`define RST_PWM_MIN 8'h80
`define RST_FAN_LIM 8'h5A
`define RST_ABS_LIM 8'h64
`define RST_HYST 8'h44
// writable bit masks (reserved bits zero)
`define MASK_ALL 8'hFF
`define MASK_MIN_OFF 8'hEF
`define MASK_PARITY_EN 8'h01
`define MASK_SPINUP 8'hF7
`define MASK_CTRL 8'h3F
// control register fields
`define CTRL_LOCK_BIT 1
`define CTRL_ALWAYS_WR 8'h09
// number of latched pairs
`define NUM_PAIRS 13
`endif

/* rtl/fan_cfg_pkg.sv */
package fan_cfg_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } meas_word_t;
endpackage

/* rtl/pair_lookup.sv */
`timescale 1ns/100ps
`include "fan_cfg_defs.svh"
// maps an address to its measurement pair and byte side
module pair_lookup (
  // query
  input wire logic [7:0] addr,
  // result
  output logic hit,
  output logic is_hi,
  output logic [3:0] index
);
  always_comb begin
    hit = 1'b1;
    is_hi = 1'b1;
    index = 4'h0;
    case (addr)
      8'h25: index = 4'h0;
      8'h10: begin index = 4'h0; is_hi = 1'b0; end
      8'h26: index = 4'h1;
      8'h15: begin index = 4'h1; is_hi = 1'b0; end
      8'h27: index = 4'h2;
      8'h16: begin index = 4'h2; is_hi = 1'b0; end
      8'h33: index = 4'h3;
      8'h17: begin index = 4'h3; is_hi = 1'b0; end
      8'h20: index = 4'h4;
      8'h13: begin index = 4'h4; is_hi = 1'b0; end
      8'h21: index = 4'h5;
      8'h18: begin index = 4'h5; is_hi = 1'b0; end
      8'h22: index = 4'h6;
      8'h11: begin index = 4'h6; is_hi = 1'b0; end
      8'h23: index = 4'h7;
      8'h12: begin index = 4'h7; is_hi = 1'b0; end
      8'h24: index = 4'h8;
      8'h14: begin index = 4'h8; is_hi = 1'b0; end
      8'h29: index = 4'h9;
      8'h28: begin index = 4'h9; is_hi = 1'b0; end
      8'h2B: index = 4'hA;
      8'h2A: begin index = 4'hA; is_hi = 1'b0; end
      8'h2D: index = 4'hB;
      8'h2C: begin index = 4'hB; is_hi = 1'b0; end
      8'h2F: index = 4'hC;
      8'h2E: begin index = 4'hC; is_hi = 1'b0; end
      default: begin
        hit = 1'b0;
        is_hi = 1'b0;
      end
    endcase
  end
endmodule

/* rtl/word_latch.sv */
`timescale 1ns/100ps
`include "fan_cfg_defs.svh"
// coherent two-byte read holding latch
module word_latch (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // access from the register port
  input wire logic acc,
  input wire logic rd,
  input wire logic [7:0] addr,
  // live measurement words
  input wire fan_cfg_pkg::meas_word_t live [`NUM_PAIRS],
  // read data and state
  output logic hit,
  output logic [7:0] rdata,
  output logic held
);
  logic is_hi;
  logic [3:0] index;
  logic [7:0] hold_byte;
  logic [7:0] next_hold_byte;
  logic [7:0] hold_addr;
  logic [7:0] next_hold_addr;
  logic next_held;
  logic [7:0] other_byte;
  fan_cfg_pkg::meas_word_t cur;

  pair_lookup u_lookup (
    .addr(addr),
    .hit(hit),
    .is_hi(is_hi),
    .index(index)
  );

  // partner byte as seen live, for the coherence check
  assign other_byte = is_hi ? cur.lo : cur.hi;

  always_comb begin
    cur = (hit && index < 4'(`NUM_PAIRS)) ? live[index] : '0;
    rdata = 8'h00;
    next_held = held;
    next_hold_byte = hold_byte;
    next_hold_addr = hold_addr;
    if (held && addr == hold_addr) begin
      rdata = hold_byte;
    end else if (hit) begin
      rdata = is_hi ? cur.hi : cur.lo;
    end
    if (acc) begin
      next_held = 1'b0;
      if (rd && hit && !(held && addr == hold_addr)) begin
        next_held = 1'b1;
        next_hold_byte = is_hi ? cur.lo : cur.hi;
        next_hold_addr = partner(addr);
      end
    end
  end

  // partner address of a paired byte
  function automatic logic [7:0] partner(input logic [7:0] a);
    case (a)
      8'h25: partner = 8'h10; 8'h10: partner = 8'h25;
      8'h26: partner = 8'h15; 8'h15: partner = 8'h26;
      8'h27: partner = 8'h16; 8'h16: partner = 8'h27;
      8'h33: partner = 8'h17; 8'h17: partner = 8'h33;
      8'h20: partner = 8'h13; 8'h13: partner = 8'h20;
      8'h21: partner = 8'h18; 8'h18: partner = 8'h21;
      8'h22: partner = 8'h11; 8'h11: partner = 8'h22;
      8'h23: partner = 8'h12; 8'h12: partner = 8'h23;
      8'h24: partner = 8'h14; 8'h14: partner = 8'h24;
      8'h29: partner = 8'h28; 8'h28: partner = 8'h29;
      8'h2B: partner = 8'h2A; 8'h2A: partner = 8'h2B;
      8'h2D: partner = 8'h2C; 8'h2C: partner = 8'h2D;
      8'h2F: partner = 8'h2E; 8'h2E: partner = 8'h2F;
      default: partner = 8'h00;
    endcase
  endfunction

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      held <= 1'b0;
      hold_byte <= 8'h00;
      hold_addr <= 8'h00;
    end else begin
      held <= next_held;
      hold_byte <= next_hold_byte;
      hold_addr <= next_hold_addr;
    end
  end

  property p_release_on_access;
    @(posedge clk_sys) disable iff (!arst_n)
      (held && acc && addr != hold_addr && !(rd && hit)) |=> !held;
  endproperty
  a_release_on_access: assert property (p_release_on_access) else $error("latch not released");

  property p_capture;
    @(posedge clk_sys) disable iff (!arst_n)
      (acc && rd && hit && !held) |=> held && hold_addr == partner($past(addr));
  endproperty
  a_capture: assert property (p_capture) else $error("partner not captured");

  sequence s_first_read;
    acc && rd && hit && !held;
  endsequence
  // host paces one idle cycle between accesses
  property p_coherent;
    @(posedge clk_sys) disable iff (!arst_n)
      s_first_read ##1 !acc ##1 (acc && rd && addr == hold_addr) |-> rdata == $past(other_byte, 2);
  endproperty
  a_coherent: assert property (p_coherent) else $error("torn pair read");

  property p_hold_stable;
    @(posedge clk_sys) disable iff (!arst_n)
      (held && !acc) |=> held && $stable(hold_byte);
  endproperty
  a_hold_stable: assert property (p_hold_stable) else $error("held byte changed");
endmodule

/* rtl/fan_config_regs_word_latch.sv */
`timescale 1ns/100ps
`include "fan_cfg_defs.svh"
module fan_config_regs_word_latch (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // register access from the serial interface
  input wire fan_cfg_pkg::reg_req_t req,
  // live measurements
  input wire fan_cfg_pkg::meas_word_t live [`NUM_PAIRS],
  // read answer
  output logic [7:0] rdata,
  output logic rhit,
  // configuration out
  output logic [7:0] ctrl,
  output logic [7:0] cfg [18]
);
  logic [7:0] regs [18];
  logic [7:0] next_regs [18];
  logic [7:0] next_ctrl;
  logic [7:0] next_rdata;
  logic next_rhit;
  logic locked;
  logic lat_hit;
  logic [7:0] lat_rdata;
  logic lat_held;
  logic acc;
  logic cfg_change;

  localparam logic [7:0] OFFS [18] = '{`ADDR_Z2_RANGE, `ADDR_Z3_RANGE, `ADDR_MIN_OFF, `ADDR_Z23_SMOOTH,
    `ADDR_F1_PWM_MIN, `ADDR_F2_PWM_MIN, `ADDR_F3_PWM_MIN, `ADDR_Z1_FAN_LIM, `ADDR_Z2_FAN_LIM,
    `ADDR_Z3_FAN_LIM, `ADDR_Z1_ABS_LIM, `ADDR_Z2_ABS_LIM, `ADDR_Z3_ABS_LIM, `ADDR_Z12_HYST,
    `ADDR_Z34_HYST, `ADDR_PARITY_EN, `ADDR_SPINUP, 8'h00};
  localparam logic [7:0] RSTS [18] = '{`RST_RANGE, `RST_RANGE, `RST_ZERO, `RST_ZERO, `RST_PWM_MIN,
    `RST_PWM_MIN, `RST_PWM_MIN, `RST_FAN_LIM, `RST_FAN_LIM, `RST_FAN_LIM, `RST_ABS_LIM, `RST_ABS_LIM,
    `RST_ABS_LIM, `RST_HYST, `RST_HYST, `RST_ZERO, `RST_ZERO, `RST_ZERO};

  // writable mask per slot; slot 17 is unused
  function automatic logic [7:0] wmask(input int i);
    case (i)
      2: wmask = `MASK_MIN_OFF;
      15: wmask = `MASK_PARITY_EN;
      16: wmask = `MASK_SPINUP;
      17: wmask = 8'h00;
      default: wmask = `MASK_ALL;
    endcase
  endfunction

  // true for any lockable configuration offset
  function automatic logic is_cfg_addr(input logic [7:0] a);
    is_cfg_addr = 1'b0;
    for (int i = 0; i < 17; i++) begin
      if (a == OFFS[i]) begin
        is_cfg_addr = 1'b1;
      end
    end
  endfunction

  assign locked = ctrl[`CTRL_LOCK_BIT];
  assign acc = req.wr | req.rd;

  word_latch u_latch (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .acc(acc),
    .rd(req.rd),
    .addr(req.addr),
    .live(live),
    .hit(lat_hit),
    .rdata(lat_rdata),
    .held(lat_held)
  );

  always_comb begin
    next_ctrl = ctrl;
    next_rdata = rdata;
    next_rhit = 1'b0;
    for (int i = 0; i < 18; i++) begin
      next_regs[i] = regs[i];
    end
    if (req.wr && req.addr == `ADDR_CTRL_LOCK) begin
      // lock leaves bits 0 and 3
      if (locked) begin
        next_ctrl = (ctrl & ~`CTRL_ALWAYS_WR) | (req.wdata & `CTRL_ALWAYS_WR);
      end else begin
        next_ctrl = req.wdata & `MASK_CTRL;
      end
    end
    if (req.wr && !locked) begin
      for (int i = 0; i < 17; i++) begin
        if (req.addr == OFFS[i]) begin
          next_regs[i] = req.wdata & wmask(i);
        end
      end
    end
    if (req.rd) begin
      next_rdata = 8'h00;
      next_rhit = 1'b0;
      if (lat_hit) begin
        next_rdata = lat_rdata;
        next_rhit = 1'b1;
      end else if (req.addr == `ADDR_CTRL_LOCK) begin
        next_rdata = ctrl;
        next_rhit = 1'b1;
      end else begin
        for (int i = 0; i < 17; i++) begin
          if (req.addr == OFFS[i]) begin
            next_rdata = regs[i];
            next_rhit = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= `RST_ZERO;
      rdata <= 8'h00;
      rhit <= 1'b0;
      for (int i = 0; i < 18; i++) begin
        regs[i] <= RSTS[i];
      end
    end else begin
      ctrl <= next_ctrl;
      rdata <= next_rdata;
      rhit <= next_rhit;
      for (int i = 0; i < 18; i++) begin
        regs[i] <= next_regs[i];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 18; i++) begin
        cfg[i] <= RSTS[i];
      end
    end else begin
      for (int i = 0; i < 18; i++) begin
        cfg[i] <= next_regs[i];
      end
    end
  end

  // any slot about to move, for the lock check
  always_comb begin
    cfg_change = 1'b0;
    for (int i = 0; i < 18; i++) begin
      if (next_regs[i] != regs[i]) begin
        cfg_change = 1'b1;
      end
    end
  end

  property p_lock_freeze;
    @(posedge clk_sys) disable iff (!arst_n)
      (locked && req.wr && req.addr == `ADDR_Z1_FAN_LIM) |=> $stable(regs[7]);
  endproperty
  a_lock_freeze: assert property (p_lock_freeze) else $error("locked register changed");

  property p_ctrl_lock;
    @(posedge clk_sys) disable iff (!arst_n)
      (locked && req.wr && req.addr == `ADDR_CTRL_LOCK) |=>
        ((ctrl & ~`CTRL_ALWAYS_WR) == ($past(ctrl) & ~`CTRL_ALWAYS_WR)) &&
        ((ctrl & `CTRL_ALWAYS_WR) == ($past(req.wdata) & `CTRL_ALWAYS_WR));
  endproperty
  a_ctrl_lock: assert property (p_ctrl_lock) else $error("control lock mask wrong");

  property p_reserved_zero;
    @(posedge clk_sys) disable iff (!arst_n)
      1'b1 |-> (regs[2][4] == 1'b0) && (regs[15][7:1] == 7'h00) && (regs[16][3] == 1'b0) && (ctrl[7:6] == 2'b00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_unlocked_write;
    @(posedge clk_sys) disable iff (!arst_n)
      (!locked && req.wr && req.addr == `ADDR_F1_PWM_MIN) |=> regs[4] == $past(req.wdata);
  endproperty
  a_unlocked_write: assert property (p_unlocked_write) else $error("write not stored");

  // whole bank, not just one sample slot
  property p_lock_all;
    @(posedge clk_sys) disable iff (!arst_n)
      locked |-> !cfg_change;
  endproperty
  a_lock_all: assert property (p_lock_all) else $error("locked bank changed");

  property p_lock_sticky;
    @(posedge clk_sys) disable iff (!arst_n)
      locked |=> locked;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky) else $error("lock dropped without reset");

  property p_ctrl_unlocked;
    @(posedge clk_sys) disable iff (!arst_n)
      (!locked && req.wr && req.addr == `ADDR_CTRL_LOCK) |=> ctrl == ($past(req.wdata) & `MASK_CTRL);
  endproperty
  a_ctrl_unlocked: assert property (p_ctrl_unlocked) else $error("control write wrong");

  property p_reserved_read;
    @(posedge clk_sys) disable iff (!arst_n)
      (req.rd && req.addr == `ADDR_PARITY_EN) |=> rhit && (rdata[7:1] == 7'h00);
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("reserved bit read as one");

  property p_ctrl_read;
    @(posedge clk_sys) disable iff (!arst_n)
      (req.rd && req.addr == `ADDR_CTRL_LOCK) |=> rhit && (rdata[7:6] == 2'b00);
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control reserved bits read");

  property p_unmapped_read;
    @(posedge clk_sys) disable iff (!arst_n)
      (req.rd && !lat_hit && req.addr != `ADDR_CTRL_LOCK && !is_cfg_addr(req.addr)) |=>
        !rhit && (rdata == 8'h00);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read answered");

  property p_rhit_pulse;
    @(posedge clk_sys) disable iff (!arst_n)
      !req.rd |=> !rhit;
  endproperty
  a_rhit_pulse: assert property (p_rhit_pulse) else $error("hit without read");

  // read data stands until the next read
  property p_rdata_hold;
    @(posedge clk_sys) disable iff (!arst_n)
      !req.rd |=> $stable(rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  property p_latch_read;
    @(posedge clk_sys) disable iff (!arst_n)
      (req.rd && lat_hit) |=> rhit && (rdata == $past(lat_rdata));
  endproperty
  a_latch_read: assert property (p_latch_read) else $error("pair byte not returned");

  sequence s_open_write;
    !locked && req.wr && req.addr == `ADDR_F1_PWM_MIN;
  endsequence
  sequence s_read_pwm;
    req.rd && req.addr == `ADDR_F1_PWM_MIN;
  endsequence
  property p_write_then_read;
    @(posedge clk_sys) disable iff (!arst_n)
      s_open_write ##1 !req.wr ##1 s_read_pwm |=> rdata == $past(req.wdata, 3);
  endproperty
  a_write_then_read: assert property (p_write_then_read) else $error("readback differs");
endmodule

/* dv/host_model.sv */
`timescale 1ns/100ps
// serial host side: one request per call, strobe held for exactly one edge
module host_model (
  // clock
  input wire logic clk_sys,
  // request toward the register bank
  output fan_cfg_pkg::reg_req_t req,
  // answer
  input wire logic [7:0] rdata,
  input wire logic rhit
);
  initial req = '0;

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk_sys);
    #1;
    // released lines show garbage, not the last value
    req.wr = 1'b0;
    req.addr = ~a;
    req.wdata = ~v;
    @(posedge clk_sys);
    #1;
  endtask

  // partner read next
  // caller keeps the partner read as the very next access for a coherent pair
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    #1;
    d = rdata;
    h = rhit;
    req.rd = 1'b0;
    req.addr = ~a;
    req.wdata = 8'hA5;
    @(posedge clk_sys);
    #1;
  endtask
endmodule

/* dv/fan_config_regs_word_latch_tb.sv */
`timescale 1ns/100ps
`include "fan_cfg_defs.svh"
module fan_config_regs_word_latch_tb;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  fan_cfg_pkg::reg_req_t req;
  fan_cfg_pkg::meas_word_t live [`NUM_PAIRS];
  logic [7:0] rdata;
  logic rhit;
  logic [7:0] ctrl;
  logic [7:0] cfg [18];
  int fail_count = 0;
  int samples_checked = 0;
  logic [7:0] cfg_addr [17] = '{8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h66, 8'h67, 8'h68, 8'h69,
    8'h6A, 8'h6B, 8'h6C, 8'h6D, 8'h6E, 8'h6F, 8'h75};
  logic [7:0] cfg_rst [17] = '{8'hC3, 8'hC3, 8'h00, 8'h00, 8'h80, 8'h80, 8'h80, 8'h5A, 8'h5A, 8'h5A,
    8'h64, 8'h64, 8'h64, 8'h44, 8'h44, 8'h00, 8'h00};
  logic [7:0] cfg_mask [17] = '{8'hFF, 8'hFF, 8'hEF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h01, 8'hF7};
  logic [7:0] hi_addr [13] = '{8'h25, 8'h26, 8'h27, 8'h33, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h29,
    8'h2B, 8'h2D, 8'h2F};
  logic [7:0] lo_addr [13] = '{8'h10, 8'h15, 8'h16, 8'h17, 8'h13, 8'h18, 8'h11, 8'h12, 8'h14, 8'h28,
    8'h2A, 8'h2C, 8'h2E};
  logic [7:0] d;
  logic [7:0] old;
  logic h;

  always #2.5 clk_sys = ~clk_sys;

  fan_config_regs_word_latch u_dut (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .req(req),
    .live(live),
    .rdata(rdata),
    .rhit(rhit),
    .ctrl(ctrl),
    .cfg(cfg)
  );

  host_model u_host (
    .clk_sys(clk_sys),
    .req(req),
    .rdata(rdata),
    .rhit(rhit)
  );

  task check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic eh);
    u_host.rd(a, d, h);
    check(d, exp);
    check({7'h00, h}, {7'h00, eh});
  endtask

  task complete_run;
    $display("compares %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #50000;
    fail_count++;
    complete_run;
  end

  initial begin
    // whole bytes compared, don't-care bits included
    for (int i = 0; i < `NUM_PAIRS; i++) begin
      live[i].hi = 8'hA0 + 8'(i);
      live[i].lo = 8'h50 + 8'(i);
    end
    repeat (4) @(posedge clk_sys);
    #1;
    arst_n = 1'b1;
    for (int i = 0; i < 17; i++) begin
      rd_chk(cfg_addr[i], cfg_rst[i], 1'b1);
      check(cfg[i], cfg_rst[i]);
    end
    rd_chk(`ADDR_CTRL_LOCK, 8'h00, 1'b1);
    $display("test reset_values done");
    for (int i = 0; i < `NUM_PAIRS; i++) begin
      u_host.rd(hi_addr[i], d, h);
      check(d, live[i].hi);
      old = live[i].lo;
      live[i] = ~live[i];
      rd_chk(lo_addr[i], old, 1'b1);
      u_host.rd(lo_addr[i], d, h);
      check(d, live[i].lo);
      old = live[i].hi;
      live[i] = ~live[i];
      rd_chk(hi_addr[i], old, 1'b1);
    end
    $display("test pair_latch done");
    u_host.rd(hi_addr[0], d, h);
    live[0] = ~live[0];
    rd_chk(8'h61, 8'hC3, 1'b1);
    rd_chk(lo_addr[0], live[0].lo, 1'b1);
    u_host.rd(lo_addr[1], d, h);
    live[1] = ~live[1];
    u_host.wr(8'h63, 8'h5A);
    rd_chk(hi_addr[1], live[1].hi, 1'b1);
    $display("test latch_release done");
    for (int i = 0; i < 17; i++) begin
      u_host.wr(cfg_addr[i], 8'hFF);
      rd_chk(cfg_addr[i], cfg_mask[i], 1'b1);
      check(cfg[i], cfg_mask[i]);
    end
    rd_chk(8'h7F, 8'h00, 1'b0);
    u_host.wr(`ADDR_CTRL_LOCK, 8'hFD);
    rd_chk(`ADDR_CTRL_LOCK, 8'h3D, 1'b1);
    $display("test write_readback done");
    u_host.wr(`ADDR_CTRL_LOCK, 8'h02);
    check(ctrl, 8'h02);
    for (int i = 0; i < 17; i++) begin
      u_host.wr(cfg_addr[i], 8'h00);
      rd_chk(cfg_addr[i], cfg_mask[i], 1'b1);
      check(cfg[i], cfg_mask[i]);
    end
    u_host.wr(`ADDR_CTRL_LOCK, 8'h3D);
    rd_chk(`ADDR_CTRL_LOCK, 8'h0B, 1'b1);
    u_host.wr(`ADDR_CTRL_LOCK, 8'h00);
    rd_chk(`ADDR_CTRL_LOCK, 8'h02, 1'b1);
    $display("test lock done");
    arst_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    arst_n = 1'b1;
    rd_chk(8'h60, 8'hC3, 1'b1);
    u_host.wr(8'h60, 8'h12);
    rd_chk(8'h60, 8'h12, 1'b1);
    $display("test reset_unlock done");
    complete_run;
  end
endmodule
